// [include/phone_mode_regs.svh]
// Offsets, field positions, reset values and timing counts of the sequencer
// What this block does
// - Both hooks open, no ring: idle, silent
// - Ringing: oscillator runs, valid ring reported
// - Ring supply up: start oscillator, check frequency
// - Valid ring: send line change, start watchdog
// - Unacknowledged at expiry: backup mode, play melody
// - Backup: keyscan on while off hook, handset path, serial available
// - Own dialling, once begun, is never interrupted
// - Backup to main only before own dialling
// - Main mode: keyscan off, one serial route
// - Route commands set the three analog switches
// - Supply up: handset on, hook starts scan, settings
// - Backup start-up also sends line change
// - Tone dialling feeds attenuated comfort tone
// - Strap sampled once per off-hook, then held
// - Strap pattern decodes compensation and tone level
// - Serial frames 9600 baud 8N1, LSB first
`ifndef PHONE_MODE_REGS_SVH
`define PHONE_MODE_REGS_SVH

`define CLK_HZ         100000000
`define BAUD           9600
`define OVS            16
`define BAUD16_CYC     (`CLK_HZ / (`BAUD * `OVS))
`define SCAN_STEP_US   10
`define SCAN_STEP_CYC  (`SCAN_STEP_US * (`CLK_HZ / 1000000))
`define MEL_HALF_A     7'h30
`define MEL_HALF_B     7'h40
`define MEL_HALF_C     7'h50

`define ADDR_CTRL      8'h00
`define ADDR_STATE     8'h04
`define ADDR_ISTS      8'h08
`define ADDR_IMASK     8'h0c
`define CTRL_MELODY    0
`define CTRL_RST       1'h1
`define IMASK_RST      5'h00

`define EV_RING        0
`define EV_WDOG        1
`define EV_LINE        2
`define EV_CMD         3
`define EV_SCAN        4

`define CMD_HANDSET    6'h33
`define CMD_MONITOR    6'h3b
`define CMD_MODEM      6'h35
`define CMD_STATUS     6'h31
`define STAT_RING      7
`define STAT_MHS       6

`endif

// [include/phone_mode_pkg.sv]
// Types shared by the phone mode sequencer modules
package phone_mode_pkg;
  typedef enum logic [2:0] {
    IDLE = 3'h0, RING_DISC = 3'h1, RING_WDOG = 3'h3,
    FALLBACK = 3'h2, HOST = 3'h6
  } mode_t;
  typedef enum logic [1:0] {
    ROUTE_HANDSET = 2'h0, ROUTE_MONITOR = 2'h1, ROUTE_MODEM = 2'h2
  } route_t;
  typedef enum logic [1:0] {
    LLC_45_75 = 2'h0, LLC_20_50 = 2'h1, LLC_NONE = 2'h2
  } llc_t;
  typedef enum logic [1:0] {
    LVL_6DBM = 2'h0, LVL_8DBM = 2'h1, LVL_10DBM = 2'h2
  } dtmf_lvl_t;
endpackage

// [include/seq_link_if.sv]
// Carrier between the sequencer and its serial and strap-scan helpers
`timescale 1ns/1ns
interface seq_link_if;
  logic       tick;
  logic       tx_start;
  logic       tx_abort;
  logic [7:0] tx_byte;
  logic       tx_busy;
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic       scan_start;
  logic       scan_busy;
  logic [4:0] scan_result;
  modport uart (input tx_start, tx_abort, tx_byte,
                output tick, tx_busy, rx_valid, rx_byte);
  modport scan (input scan_start, output scan_busy, scan_result);
  modport ctrl (output tx_start, tx_abort, tx_byte, scan_start,
                input tick, tx_busy, rx_valid, rx_byte,
                scan_busy, scan_result);
endinterface

// [rtl/serial_8n1.sv]
// Serial 8N1 transmitter and receiver with 16x oversampling
`timescale 1ns/1ns
`include "phone_mode_regs.svh"
module serial_8n1 (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  seq_link_if.uart  lnk,
  input  wire logic rxd_i,
  output logic      txd_o,
  output logic      txd_oe_o
);
  typedef struct packed {
    logic [9:0] div;
    logic       tick;
    logic [9:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [13:0] tx_div;
    logic       rx_act;
    logic [3:0] rx_sub;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic       rx_vld;
    logic [7:0] rx_byte;
  } uart_state_t;
  uart_state_t q, d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    d.rx_vld = 1'b0;
    if (q.div == 10'(`BAUD16_CYC - 1)) begin
      d.div = 10'h000;
      d.tick = 1'b1;
    end else begin
      d.div = q.div + 10'h001;
    end
    // Own bit timer, so the start bit is a whole bit long
    if (q.tx_cnt != 4'h0) begin
      if (q.tx_div == 14'(`BAUD16_CYC * `OVS - 1)) begin
        d.tx_div = 14'h0000;
        d.tx_sh = {1'b1, q.tx_sh[9:1]};
        d.tx_cnt = q.tx_cnt - 4'h1;
      end else begin
        d.tx_div = q.tx_div + 14'h0001;
      end
    end
    if (q.tick) begin
      if (!q.rx_act) begin
        if (!rxd_i) begin
          d.rx_act = 1'b1;
          d.rx_sub = 4'h0;
          d.rx_bit = 4'h0;
        end
      end else begin
        d.rx_sub = q.rx_sub + 4'h1;
        if (q.rx_sub == 4'h7) begin
          d.rx_bit = q.rx_bit + 4'h1;
          // Mid-bit sample; a glitch on the start bit is dropped
          if (q.rx_bit == 4'h0 && rxd_i) begin
            d.rx_act = 1'b0;
          end else if (q.rx_bit == 4'h9) begin
            d.rx_act = 1'b0;
            d.rx_vld = rxd_i;
            d.rx_byte = q.rx_sh;
          end else if (q.rx_bit != 4'h0) begin
            d.rx_sh = {rxd_i, q.rx_sh[7:1]};
          end
        end
      end
    end
    if (lnk.tx_start && q.tx_cnt == 4'h0) begin
      d.tx_sh = {1'b1, lnk.tx_byte, 1'b0};
      d.tx_cnt = 4'ha;
      d.tx_div = 14'h0000;
    end
    // Idle stops the oscillator, so a frame in flight is dropped
    if (lnk.tx_abort) begin
      d.tx_cnt = 4'h0;
      d.tx_sh = 10'h3ff;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.tx_sh <= 10'h3ff;
    end else begin
      q <= d;
    end
  end

  assign lnk.tick = q.tick;
  assign lnk.tx_busy = (q.tx_cnt != 4'h0);
  assign lnk.rx_valid = q.rx_vld;
  assign lnk.rx_byte = q.rx_byte;
  // Open drain: only a low is driven
  assign txd_o = 1'b0;
  assign txd_oe_o = (q.tx_cnt != 4'h0) && !q.tx_sh[0];
endmodule

// [rtl/strap_scan.sv]
// Walks the keypad lines low one at a time and senses the mode pin
`timescale 1ns/1ns
`include "phone_mode_regs.svh"
module strap_scan (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  seq_link_if.scan        lnk,
  input  wire logic       mode_pin_i,
  output logic [4:0]      keypad_line_o,
  output logic [4:0]      keypad_line_oe_o
);
  typedef struct packed {
    logic       busy;
    logic [2:0] idx;
    logic [9:0] cnt;
    logic [4:0] res;
    logic [4:0] oe;
  } scan_state_t;
  scan_state_t q, d;

  always_comb begin
    d = q;
    if (lnk.scan_start && !q.busy) begin
      d.busy = 1'b1;
      d.idx = 3'h0;
      d.cnt = 10'h000;
      d.res = 5'h00;
    end else if (q.busy) begin
      d.cnt = q.cnt + 10'h001;
      if (q.cnt == 10'(`SCAN_STEP_CYC - 1)) begin
        // A strapped line pulls the mode pin low
        d.res[q.idx] = !mode_pin_i;
        d.cnt = 10'h000;
        d.idx = q.idx + 3'h1;
        if (q.idx == 3'h4) begin
          d.busy = 1'b0;
        end
      end
    end
    d.oe = d.busy ? (5'h01 << d.idx) : 5'h00;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.scan_busy = q.busy;
  assign lnk.scan_result = q.res;
  assign keypad_line_o = 5'h00;
  assign keypad_line_oe_o = q.oe;
endmodule

// [rtl/phone_mode_sequencer.sv]
// Mode, ring watchdog, route and strap control of the line-powered phone
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
`include "phone_mode_regs.svh"
module phone_mode_sequencer #(
  parameter int WDOG_MS     = 1000,
  parameter int RING_MIN_US = 14700,
  parameter int RING_MAX_US = 66700
) (
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  input  wire logic [7:0]              addr_i,
  input  wire logic [31:0]             wdata_i,
  input  wire logic                    we_i,
  input  wire logic                    re_i,
  output logic [31:0]                  rdata_o,
  output logic                         irq_o,
  input  wire logic                    manual_hook_input_i,
  input  wire logic                    electronic_hook_input_i,
  input  wire logic                    ring_supply_i,
  input  wire logic                    supply_ok_i,
  input  wire logic                    ring_discrimination_input_i,
  input  wire logic                    dial_started_i,
  input  wire logic                    tone_dialling_i,
  input  wire logic                    mode_pin_i,
  input  wire logic                    rxd_i,
  output logic                         txd_o,
  output logic                         txd_oe_o,
  output logic                         osc_run_o,
  output logic                         keyscan_en_o,
  output logic                         melody_output_o,
  output logic                         earpiece_out_switch_o,
  output logic                         transformer_out_switch_o,
  output logic                         transformer_in_switch_o,
  output logic                         comfort_tone_o,
  output logic [4:0]                   keypad_line_o,
  output logic [4:0]                   keypad_line_oe_o,
  output phone_mode_pkg::llc_t         loss_compensation_range_o,
  output phone_mode_pkg::dtmf_lvl_t    dtmf_level_o
);
  import phone_mode_pkg::*;

  localparam int CYC_PER_US = `CLK_HZ / 1000000;
  localparam int WDOG_CYC   = WDOG_MS * 1000 * CYC_PER_US;
  localparam int RING_MIN   = RING_MIN_US * CYC_PER_US;
  localparam int RING_MAX   = RING_MAX_US * CYC_PER_US;

  typedef struct packed {
    mode_t      mode;
    logic [31:0] wdog;
    logic       acked;
    logic [23:0] per;
    logic       rfd_d;
    logic [1:0] ring_ok;
    logic       hook_d;
    logic       scan_d;
    route_t     route;
    logic [2:0] sw;
    logic [4:0] strap;
    llc_t       loss_compensation_range;
    dtmf_lvl_t  lvl;
    logic       tx_pend;
    logic [7:0] tx_byte;
    logic       scan_go;
    logic       ctrl_mel;
    logic [4:0] ists;
    logic [4:0] imask;
    logic       irq;
    logic [31:0] rdata;
    logic [6:0] mel_cnt;
    logic [11:0] mel_seq;
    logic       mel;
    logic       osc;
    logic       keyscan;
    logic       comfort;
  } seq_state_t;
  seq_state_t q, d;

  seq_link_if lnk ();

  serial_8n1 u_serial (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .lnk      (lnk.uart),
    .rxd_i    (rxd_i),
    .txd_o    (txd_o),
    .txd_oe_o (txd_oe_o)
  );

  strap_scan u_scan (
    .clk_i            (clk_i),
    .resetn_i         (resetn_i),
    .lnk              (lnk.scan),
    .mode_pin_i       (mode_pin_i),
    .keypad_line_o    (keypad_line_o),
    .keypad_line_oe_o (keypad_line_oe_o)
  );

  // Strap pattern {c3,c2,c1,r2,r1} to loss compensation and tone level
  function automatic logic [3:0] strap_decode(input logic [4:0] s);
    logic [3:0] r;
    r = {LLC_45_75, LVL_6DBM};
    unique case (s)
      5'h03:   r = {LLC_45_75, LVL_8DBM};
      5'h04:   r = {LLC_45_75, LVL_10DBM};
      5'h08:   r = {LLC_20_50, LVL_6DBM};
      5'h10:   r = {LLC_20_50, LVL_8DBM};
      5'h0c:   r = {LLC_20_50, LVL_10DBM};
      5'h14:   r = {LLC_NONE, LVL_6DBM};
      5'h18:   r = {LLC_NONE, LVL_8DBM};
      5'h1c:   r = {LLC_NONE, LVL_10DBM};
      default: r = {LLC_45_75, LVL_6DBM};
    endcase
    return r;
  endfunction

  // Half period of the three-tone melody, four steps per phrase
  function automatic logic [6:0] mel_half(input logic [1:0] step);
    logic [6:0] h;
    h = `MEL_HALF_B;
    unique case (step)
      2'h0: h = `MEL_HALF_A;
      2'h1: h = `MEL_HALF_B;
      2'h2: h = `MEL_HALF_C;
      2'h3: h = `MEL_HALF_B;
    endcase
    return h;
  endfunction

  // Status byte also serves as the line change message
  function automatic logic [7:0] status_byte(input logic ring,
                                             input logic manual_hook_input,
                                             input logic electronic_hook_input);
    logic [7:0] b;
    b = 8'h01;
    b[`STAT_RING] = ring;
    b[`STAT_MHS] = manual_hook_input;
    b[5] = electronic_hook_input;
    return b;
  endfunction

  logic       hook;
  logic       hook_rise;
  logic       rfd_rise;
  logic       cmd_ok;
  logic [5:0] cmd;
  logic [4:0] ev;
  logic       rd_ists;
  logic [3:0] dec;

  always_comb begin
    hook = manual_hook_input_i | electronic_hook_input_i;
    hook_rise = hook && !q.hook_d;
    rfd_rise = ring_discrimination_input_i && !q.rfd_d;
    // No commands are heard while the oscillator is stopped
    cmd_ok = lnk.rx_valid && lnk.rx_byte[0] && (q.mode != IDLE);
    cmd = lnk.rx_byte[5:0];
    rd_ists = re_i && (addr_i == `ADDR_ISTS);
    dec = strap_decode(lnk.scan_result);
    ev = 5'h00;
    d = q;
    d.hook_d = hook;
    d.rfd_d = ring_discrimination_input_i;
    d.scan_d = lnk.scan_busy;
    d.scan_go = 1'b0;
    d.rdata = 32'h0000_0000;

    unique case (q.mode)
      IDLE: begin
        if (hook && supply_ok_i) begin
          d.mode = FALLBACK;
          d.tx_pend = 1'b1;
          d.tx_byte = status_byte(1'b0, manual_hook_input_i,
                                  electronic_hook_input_i);
        end else if (ring_supply_i && supply_ok_i) begin
          d.mode = RING_DISC;
          d.per = 24'h000000;
          d.ring_ok = 2'h0;
        end
      end
      RING_DISC: begin
        if (q.per != 24'(RING_MAX + 1)) begin
          d.per = q.per + 24'h000001;
        end
        if (hook) begin
          d.mode = FALLBACK;
          d.tx_pend = 1'b1;
          d.tx_byte = status_byte(1'b0, manual_hook_input_i,
                                  electronic_hook_input_i);
        end else if (!ring_supply_i) begin
          d.mode = IDLE;
        end else if (rfd_rise) begin
          d.per = 24'h000000;
          // Two good periods in a row reject bursts of noise
          if (q.per >= 24'(RING_MIN) && q.per <= 24'(RING_MAX)) begin
            d.ring_ok = q.ring_ok + 2'h1;
            if (q.ring_ok == 2'h1) begin
              d.mode = RING_WDOG;
              d.wdog = 32'h0000_0000;
              d.acked = 1'b0;
              d.tx_pend = 1'b1;
              d.tx_byte = status_byte(1'b1, 1'b0, 1'b0);
              ev[`EV_RING] = 1'b1;
            end
          end else begin
            d.ring_ok = 2'h0;
          end
        end
      end
      RING_WDOG: begin
        if (cmd_ok) begin
          d.acked = 1'b1;
        end
        if (hook) begin
          d.mode = (q.acked || cmd_ok) ? HOST : FALLBACK;
          d.tx_pend = 1'b1;
          d.tx_byte = status_byte(1'b0, manual_hook_input_i,
                                  electronic_hook_input_i);
        end else if (!ring_supply_i) begin
          d.mode = IDLE;
        end else if (!q.acked && !cmd_ok) begin
          d.wdog = q.wdog + 32'h0000_0001;
          if (q.wdog == 32'(WDOG_CYC - 1)) begin
            d.mode = FALLBACK;
            ev[`EV_WDOG] = 1'b1;
          end
        end
      end
      FALLBACK: begin
        if (!hook && !ring_supply_i) begin
          d.mode = IDLE;
        end else if (hook && cmd_ok && !dial_started_i) begin
          d.mode = HOST;
        end
        // Once own dialling has begun nothing above moves us on
        if (hook && dial_started_i) begin
          d.mode = FALLBACK;
        end
      end
      HOST: begin
        if (!hook) begin
          d.mode = IDLE;
        end else if (cmd_ok) begin
          unique case (cmd)
            `CMD_HANDSET: d.route = ROUTE_HANDSET;
            `CMD_MONITOR: d.route = ROUTE_MONITOR;
            `CMD_MODEM:   d.route = ROUTE_MODEM;
            default:      d.route = q.route;
          endcase
        end
      end
      default: d.mode = IDLE;
    endcase

    if (cmd_ok) begin
      ev[`EV_CMD] = 1'b1;
      if (cmd == `CMD_STATUS) begin
        d.tx_pend = 1'b1;
        d.tx_byte = status_byte(q.mode == RING_WDOG,
                                manual_hook_input_i,
                                electronic_hook_input_i);
      end
    end

    // Backup mode always forces the handset route
    if (d.mode != HOST) begin
      d.route = ROUTE_HANDSET;
    end
    unique case (d.route)
      ROUTE_MONITOR: d.sw = 3'b110;
      ROUTE_MODEM:   d.sw = 3'b011;
      default:       d.sw = 3'b100;
    endcase
    if (d.mode != FALLBACK && d.mode != HOST) begin
      d.sw = 3'b000;
    end

    d.osc = (d.mode != IDLE);
    d.keyscan = (d.mode == FALLBACK) && hook;
    if (d.mode == HOST) begin
      d.keyscan = 1'b0;
    end
    d.comfort = tone_dialling_i && hook &&
                (q.mode == FALLBACK || q.mode == HOST);

    if (hook_rise && supply_ok_i) begin
      d.scan_go = 1'b1;
    end
    if (q.scan_d && !lnk.scan_busy) begin
      d.strap = lnk.scan_result;
      d.loss_compensation_range = llc_t'(dec[3:2]);
      d.lvl = dtmf_lvl_t'(dec[1:0]);
      ev[`EV_SCAN] = 1'b1;
    end

    // Idle never talks on the link
    if (q.tx_pend && !lnk.tx_busy && q.mode != IDLE) begin
      d.tx_pend = 1'b0;
      ev[`EV_LINE] = 1'b1;
    end
    if (d.mode == IDLE) begin
      d.tx_pend = 1'b0;
    end

    // Melody only while ringing in backup with hooks open
    if (q.mode == FALLBACK && !hook && ring_supply_i && q.ctrl_mel) begin
      if (lnk.tick) begin
        d.mel_seq = q.mel_seq + 12'h001;
        d.mel_cnt = q.mel_cnt + 7'h01;
        if (q.mel_cnt >= mel_half(q.mel_seq[11:10])) begin
          d.mel_cnt = 7'h00;
          d.mel = !q.mel;
        end
      end
    end else begin
      d.mel = 1'b0;
      d.mel_cnt = 7'h00;
      d.mel_seq = 12'h000;
    end

    if (we_i) begin
      if (addr_i == `ADDR_CTRL) begin
        d.ctrl_mel = wdata_i[`CTRL_MELODY];
      end else if (addr_i == `ADDR_IMASK) begin
        d.imask = wdata_i[4:0];
      end
    end
    if (re_i) begin
      unique case (addr_i)
        `ADDR_CTRL:  d.rdata = {31'h0, q.ctrl_mel};
        `ADDR_STATE: d.rdata = {16'h0, dial_started_i, q.acked, q.lvl,
                                q.loss_compensation_range, q.strap, q.route, q.mode};
        `ADDR_ISTS:  d.rdata = {27'h0, q.ists};
        `ADDR_IMASK: d.rdata = {27'h0, q.imask};
        default:     d.rdata = 32'h0000_0000;
      endcase
    end
    // A new event beats the clear of the same read
    d.ists = (rd_ists ? 5'h00 : q.ists) | ev;
    d.irq = |(d.ists & d.imask);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.ctrl_mel <= `CTRL_RST;
      q.imask <= `IMASK_RST;
    end else begin
      q <= d;
    end
  end

  assign lnk.tx_start = q.tx_pend && q.mode != IDLE;
  assign lnk.tx_abort = (d.mode == IDLE);
  assign lnk.tx_byte = q.tx_byte;
  assign lnk.scan_start = q.scan_go;
  assign rdata_o = q.rdata;
  assign irq_o = q.irq;
  assign osc_run_o = q.osc;
  assign keyscan_en_o = q.keyscan;
  assign melody_output_o = q.mel;
  assign earpiece_out_switch_o = q.sw[2];
  assign transformer_out_switch_o = q.sw[1];
  assign transformer_in_switch_o = q.sw[0];
  assign comfort_tone_o = q.comfort;
  assign loss_compensation_range_o = q.loss_compensation_range;
  assign dtmf_level_o = q.lvl;
endmodule

// [verif/phone_mode_monitor.sv]
// Port-level assertions for the phone mode sequencer
`timescale 1ns/1ns
`include "phone_mode_regs.svh"
module phone_mode_monitor (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       manual_hook_input_i,
  input  wire logic       electronic_hook_input_i,
  input  wire logic       ring_supply_i,
  input  wire logic       tone_dialling_i,
  input  wire logic       txd_oe_o,
  input  wire logic       osc_run_o,
  input  wire logic       keyscan_en_o,
  input  wire logic       melody_output_o,
  input  wire logic       earpiece_out_switch_o,
  input  wire logic       transformer_out_switch_o,
  input  wire logic       transformer_in_switch_o,
  input  wire logic       comfort_tone_o,
  input  wire logic [4:0] keypad_line_oe_o
);
  localparam int BIT = `BAUD16_CYC * `OVS;
  logic [31:0] run_q;
  logic [2:0]  sw;
  assign sw = {earpiece_out_switch_o, transformer_out_switch_o,
               transformer_in_switch_o};
  // Length of the current low run on the link
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i)
      run_q <= 32'h0;
    else
      run_q <= txd_oe_o ? run_q + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_idle_quiet: assert property (
    !osc_run_o |-> !txd_oe_o && !keyscan_en_o)
    else $error("link or keyscan active while oscillator stopped");
  chk_backup_route: assert property (
    keyscan_en_o |-> sw == 3'h4)
    else $error("keyscan on without handset path only");
  chk_route_set: assert property (
    sw inside {3'h0, 3'h4, 3'h6, 3'h3})
    else $error("switch set matches no route");
  chk_comfort_tone: assert property (
    tone_dialling_i && keyscan_en_o |=> comfort_tone_o)
    else $error("comfort tone missing during tone dialling");
  chk_scan_onehot: assert property (
    $onehot0(keypad_line_oe_o))
    else $error("more than one keypad line driven");
  chk_scan_offhook: assert property (
    |keypad_line_oe_o |-> manual_hook_input_i || electronic_hook_input_i)
    else $error("strap scan while on hook");
  chk_bit_length: assert property (
    $fell(txd_oe_o) && osc_run_o |-> run_q % BIT == 0)
    else $error("low run on link not whole bits");
  chk_melody_ring: assert property (
    melody_output_o |-> $past(ring_supply_i && !manual_hook_input_i
                              && !electronic_hook_input_i))
    else $error("melody outside ringing with hooks open");
  cover property ($rose(melody_output_o));
  cover property ($rose(keyscan_en_o));
  cover property ($rose(transformer_in_switch_o));
  cover property ($rose(txd_oe_o));
endmodule
bind phone_mode_sequencer phone_mode_monitor u_mon (.*);

// [verif/uart_host_model.sv]
// Host side of the serial link, 8N1 frames
`timescale 1ns/1ns
`include "phone_mode_regs.svh"
module uart_host_model (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      rxd_o
);
  localparam int BIT = `BAUD16_CYC * `OVS;
  logic [7:0] rx_byte;
  int         rx_cnt;
  initial begin
    rxd_o = 1'b1;
    rx_cnt = 0;
    rx_byte = 8'h0;
  end
  // Any valid byte with bit 0 set also acknowledges a pending line change
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (BIT) @(posedge clk_i);
    end
  endtask
  always begin : rx
    @(negedge line_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      rx_byte[i] = line_i;
    end
    repeat (BIT) @(posedge clk_i);
    if (line_i)
      rx_cnt++;
  end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the phone mode sequencer
`timescale 1ns/1ns
module tb_top;
  import phone_mode_pkg::*;
  localparam logic [4:0] PAT [9] = '{5'h00, 5'h03, 5'h04, 5'h08, 5'h10,
                                    5'h0c, 5'h14, 5'h18, 5'h1c};
  localparam logic [3:0] EXP [9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5,
                                    4'h6, 4'h8, 4'h9, 4'ha};
  logic        clk_i, resetn_i, we_i, re_i, irq_o, ring_en, line;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, d;
  logic        manual_hook_input_i, electronic_hook_input_i;
  logic        ring_supply_i, supply_ok_i, ring_discrimination_input_i;
  logic        dial_started_i, tone_dialling_i, mode_pin_i, rxd_i;
  logic        txd_o, txd_oe_o, osc_run_o, keyscan_en_o, melody_output_o;
  logic        earpiece_out_switch_o, transformer_out_switch_o;
  logic        transformer_in_switch_o, comfort_tone_o;
  logic [4:0]  keypad_line_o, keypad_line_oe_o, strap;
  logic [2:0]  sw;
  llc_t        loss_compensation_range_o;
  dtmf_lvl_t   dtmf_level_o;
  int          n_fail, n_tests, rcnt;
  assign sw = {earpiece_out_switch_o, transformer_out_switch_o,
               transformer_in_switch_o};
  // Link and mode pin both rest high through pull-ups
  assign line = txd_oe_o ? txd_o : 1'b1;
  assign mode_pin_i = ~|(keypad_line_oe_o & strap);
  phone_mode_sequencer #(.WDOG_MS(1), .RING_MIN_US(10))
    u_dut (.*);
  uart_host_model u_host (.clk_i, .line_i(line), .rxd_o(rxd_i));
  always #5 clk_i = ~clk_i;
  // Ring wave of 4000 cycles, inside the shortened valid band
  always @(posedge clk_i) begin
    rcnt <= (rcnt == 1999) ? 0 : rcnt + 1;
    if (ring_en && rcnt == 1999)
      ring_discrimination_input_i <= ~ring_discrimination_input_i;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic wait_mode(input logic [2:0] m, input int n);
    rd(8'h04);
    for (int i = 0; i < n && d[2:0] !== m; i++)
      rd(8'h04);
  endtask
  task automatic t_idle;
    rd(8'h04);
    check(d[2:0], 3'h0);
    check(osc_run_o, 1'b0);
    rd(8'h00);
    check(d, 32'h1);
    rd(8'h0c);
    check(d, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40);
    check(d, 32'h0);
  endtask
  task automatic t_ring;
    int c0;
    c0 = u_host.rx_cnt;
    wr(8'h0c, 32'h1);
    @(posedge clk_i);
    {ring_supply_i, supply_ok_i, ring_en} <= 3'h7;
    wait_mode(3'h3, 10000);
    check(d[2:0], 3'h3);
    check(osc_run_o, 1'b1);
    ring_en <= 1'b0;
    tick(2);
    check(irq_o, 1'b1);
    rd(8'h08);
    check(d[0], 1'b1);
    tick(2);
    check(irq_o, 1'b0);
    wait_mode(3'h2, 60000);
    check(d[2:0], 3'h2);
    for (int i = 0; i < 40000 && !melody_output_o; i++)
      @(posedge clk_i);
    check(melody_output_o, 1'b1);
    check(u_host.rx_cnt > c0, 1'b1);
    check({u_host.rx_byte[7], u_host.rx_byte[1:0]}, 3'h5);
    {ring_supply_i, supply_ok_i} <= 2'h0;
    wait_mode(3'h0, 100);
    check(d[2:0], 3'h0);
    check(osc_run_o, 1'b0);
  endtask
  task automatic t_strap;
    int c0;
    c0 = u_host.rx_cnt;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_i);
      strap <= PAT[i];
      supply_ok_i <= 1'b1;
      {electronic_hook_input_i, manual_hook_input_i} <= (i % 2) ? 2'h2 : 2'h1;
      tick(6000);
      check({loss_compensation_range_o, dtmf_level_o}, EXP[i]);
      check({keyscan_en_o, sw}, 4'hc);
      strap <= ~PAT[i];
      tick(2000);
      check({loss_compensation_range_o, dtmf_level_o}, EXP[i]);
      if (i == 0) begin
        for (int j = 0; j < 250000 && u_host.rx_cnt == c0; j++)
          @(posedge clk_i);
        check({u_host.rx_byte[6], u_host.rx_byte[1:0]}, 3'h5);
      end
      if (i < 8)
        {electronic_hook_input_i, manual_hook_input_i} <= 2'h0;
      tick(100);
    end
  endtask
  task automatic t_main;
    {dial_started_i, tone_dialling_i} <= 2'h3;
    tick(3);
    check(comfort_tone_o, 1'b1);
    u_host.send(8'h35);
    tick(200);
    rd(8'h04);
    check(d[2:0], 3'h2);
    check(sw, 3'h4);
    {dial_started_i, tone_dialling_i} <= 2'h0;
    u_host.send(8'h35);
    tick(200);
    rd(8'h04);
    check(d[2:0], 3'h6);
    check({keyscan_en_o, sw}, 4'h4);
    u_host.send(8'h35);
    tick(200);
    check({keyscan_en_o, sw}, 4'h3);
    u_host.send(8'h3b);
    tick(200);
    check(sw, 3'h6);
  endtask
  initial begin
    {clk_i, resetn_i, we_i, re_i, ring_en, strap} = 10'h0;
    {addr_i, wdata_i, rcnt, n_fail, n_tests} = 136'h0;
    {manual_hook_input_i, electronic_hook_input_i} = 2'h0;
    {ring_supply_i, supply_ok_i, ring_discrimination_input_i} = 3'h0;
    {dial_started_i, tone_dialling_i} = 2'h0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_idle();
    t_ring();
    t_strap();
    t_main();
    summarize();
  end
  initial begin
    #20000000;
    $display("mismatch at %0t: timeout", $time);
    n_fail++;
    summarize();
  end
endmodule
